// *** logic/psnp_defines.vh ***
/*
 * Constants for the PHY status and next-page register logic: register
 * addresses, field positions, reset values and widths.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef PSNP_DEFINES_VH
`define PSNP_DEFINES_VH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define PSNP_AW               5
`define PSNP_DW               16
`define PSNP_ADDR_NEXT_PAGE   5'h07
`define PSNP_ADDR_SUMMARY     5'h10
`define PSNP_ADDR_IRQ_STATUS  5'h12
`define PSNP_ADDR_IRQ_MASK    5'h13
`define PSNP_ADDR_FALSE_CARR  5'h14
`define PSNP_ADDR_RX_ERR      5'h15
`define PSNP_ADDR_PCS_CFG     5'h16
`define PSNP_ADDR_PHY_CTRL    5'h19
`define PSNP_ADDR_TENBASE     5'h1A

// ----------------------------------------------------------------------
// next-page transmit fields
// ----------------------------------------------------------------------
`define PSNP_NP_CODE_HI       10
`define PSNP_NP_CODE_W        11
`define PSNP_NP_CODE_RST      11'h001
`define PSNP_NP_TOGGLE_BIT    11
`define PSNP_NP_ACK2_BIT      12
`define PSNP_NP_MSG_BIT       13
`define PSNP_NP_NEXT_BIT      15
`define PSNP_NP_MSG_RST       1'b1

// ----------------------------------------------------------------------
// summary status fields
// ----------------------------------------------------------------------
`define PSNP_ST_LOW_W         9
`define PSNP_ST_LOW_ZERO      9'h000

// ----------------------------------------------------------------------
// control and event fields
// ----------------------------------------------------------------------
`define PSNP_CFG_QUALIFY_BIT  8
`define PSNP_CTRL_FORCE_BIT   14
`define PSNP_CTRL_AUTO_BIT    15
`define PSNP_CTRL_AUTO_RST    1'b1
`define PSNP_TEN_POL_BIT      4
`define PSNP_CNT_W            8
`define PSNP_CNT_MAX          8'hFF
`define PSNP_CNT_ONE          8'h01
`define PSNP_EV_W             4
`define PSNP_EV_RX_ERR        0
`define PSNP_EV_FALSE_CARR    1
`define PSNP_EV_POLARITY      2
`define PSNP_EV_SIG_LOSS      3
`define PSNP_LH_W             2
`define PSNP_LH_RX_ERR        0
`define PSNP_LH_FALSE_CARR    1
`define PSNP_LL_W             2
`define PSNP_LL_DETECT        0
`define PSNP_LL_LOCK          1

`endif

// *** logic/psnp_event_counter.v ***
/*
 * Saturating event counter with a sticky flag, both cleared by a read
 * of the counter register.
 * Assumes one clock, synchronous active-low reset, one-cycle read pulse.
 */
`timescale 1ns/1ps
`include "psnp_defines.vh"

module psnp_event_counter (
	// clock and reset
	input  wire                     clock_i,
	input  wire                     rst_b_i,
	// event and clear
	input  wire                     event_i,
	input  wire                     clear_i,
	// state
	output reg  [`PSNP_CNT_W-1:0]   count_o,
	output reg                      flag_o
);

	always @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			count_o <= {`PSNP_CNT_W{1'b0}};
			flag_o  <= 1'b0;
		end
		else if (clear_i)
		begin
			// an event in the clearing cycle is kept, not lost
			count_o <= event_i ? `PSNP_CNT_ONE : {`PSNP_CNT_W{1'b0}};
			flag_o  <= event_i;
		end
		else if (event_i)
		begin
			if (count_o != `PSNP_CNT_MAX)
				count_o <= count_o + `PSNP_CNT_ONE;
			flag_o <= 1'b1;
		end
	end

endmodule // psnp_event_counter

// *** logic/psnp_latch_low.v ***
/*
 * Latch-low status bit: any low of the live source is held until a read,
 * which reloads the bit from the live value; between reads the bit can only fall.
 * Assumes one clock, synchronous active-low reset, one-cycle read pulse.
 */
`timescale 1ns/1ps

module psnp_latch_low (
	// clock and reset
	input  wire clock_i,
	input  wire rst_b_i,
	// source and read
	input  wire live_i,
	input  wire read_i,
	// held value
	output reg  held_o
);

	always @(posedge clock_i)
	begin
		if (!rst_b_i)
			held_o <= 1'b0;
		else if (read_i)
			held_o <= live_i;
		else
			held_o <= held_o & live_i;
	end

endmodule // psnp_latch_low

// *** logic/psnp_regs.v ***
/*
 * Register logic for the next-page transmit register and the upper bits
 * of the PHY summary status register, with the counters, control bits and
 * interrupt that feed them.
 * Assumes live status inputs synchronous to clock_i, a single-cycle
 * read or write strobe, and read data taken one cycle after the read.
 */
`timescale 1ns/1ps
`include "psnp_defines.vh"

module psnp_regs (
	// clock and reset
	input  wire                     clock_i,
	input  wire                     rst_b_i,
	// register port
	input  wire [`PSNP_AW-1:0]      addr_i,
	input  wire [`PSNP_DW-1:0]      wdata_i,
	input  wire                     wr_i,
	input  wire                     rd_i,
	output reg  [`PSNP_DW-1:0]      rdata_o,
	// live status from datapath and link logic
	input  wire                     xover_swap_i,
	input  wire                     rx_error_i,
	input  wire                     false_carrier_i,
	input  wire                     polarity_inverted_i,
	input  wire                     raw_signal_detect_i,
	input  wire                     descrambler_lock_i,
	input  wire                     toggle_tx_i,
	// outputs to the link logic
	output reg  [`PSNP_NP_CODE_W-1:0] np_code_o,
	output reg                      message_page_flag_o,
	output reg                      crossover_state_o,
	output reg                      irq_o
);

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	wire rd_summary = rd_i && (addr_i == `PSNP_ADDR_SUMMARY);
	wire rd_rx_err  = rd_i && (addr_i == `PSNP_ADDR_RX_ERR);
	wire rd_fc      = rd_i && (addr_i == `PSNP_ADDR_FALSE_CARR);
	wire rd_ten     = rd_i && (addr_i == `PSNP_ADDR_TENBASE);
	wire wr_np      = wr_i && (addr_i == `PSNP_ADDR_NEXT_PAGE);
	wire wr_cfg     = wr_i && (addr_i == `PSNP_ADDR_PCS_CFG);
	wire wr_ctrl    = wr_i && (addr_i == `PSNP_ADDR_PHY_CTRL);
	wire wr_istat   = wr_i && (addr_i == `PSNP_ADDR_IRQ_STATUS);
	wire wr_imask   = wr_i && (addr_i == `PSNP_ADDR_IRQ_MASK);

	// ------------------------------------------------------------------
	// next-page transmit register
	// ------------------------------------------------------------------
	reg next_page_flag;
	reg ack2_flag;

	always @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			np_code_o           <= `PSNP_NP_CODE_RST;
			message_page_flag_o <= `PSNP_NP_MSG_RST;
			next_page_flag      <= 1'b0;
			ack2_flag           <= 1'b0;
		end
		else if (wr_np)
		begin
			np_code_o           <= wdata_i[`PSNP_NP_CODE_HI:0];
			message_page_flag_o <= wdata_i[`PSNP_NP_MSG_BIT];
			next_page_flag      <= wdata_i[`PSNP_NP_NEXT_BIT];
			ack2_flag           <= wdata_i[`PSNP_NP_ACK2_BIT];
		end
	end

	// ------------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------------
	reg qualify_detect;
	reg crossover_auto_enable;
	reg crossover_force;

	always @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			qualify_detect        <= 1'b0;
			crossover_auto_enable <= `PSNP_CTRL_AUTO_RST;
			crossover_force       <= 1'b0;
		end
		else
		begin
			if (wr_cfg)
				qualify_detect <= wdata_i[`PSNP_CFG_QUALIFY_BIT];
			if (wr_ctrl)
			begin
				crossover_auto_enable <= wdata_i[`PSNP_CTRL_AUTO_BIT];
				crossover_force       <= wdata_i[`PSNP_CTRL_FORCE_BIT];
			end
		end
	end

	// ------------------------------------------------------------------
	// crossover state
	// ------------------------------------------------------------------
	// force wins over the algorithm; with neither, pairs stay normal
	always @(posedge clock_i)
	begin
		if (!rst_b_i)
			crossover_state_o <= 1'b0;
		else if (crossover_force)
			crossover_state_o <= 1'b1;
		else if (crossover_auto_enable)
			crossover_state_o <= xover_swap_i;
		else
			crossover_state_o <= 1'b0;
	end

	// ------------------------------------------------------------------
	// latched-high events and counters
	// ------------------------------------------------------------------
	wire [`PSNP_LH_W-1:0]             lh_event;
	wire [`PSNP_LH_W-1:0]             lh_clear;
	wire [`PSNP_LH_W-1:0]             lh_flag;
	wire [`PSNP_LH_W*`PSNP_CNT_W-1:0] lh_count;
	wire [`PSNP_CNT_W-1:0]            rx_err_count;
	wire [`PSNP_CNT_W-1:0]            fc_count;
	wire                              rx_err_latch;
	wire                              fc_latch;

	// a counter read clears its own flag only; status reads never do
	assign lh_event[`PSNP_LH_RX_ERR]     = rx_error_i;
	assign lh_event[`PSNP_LH_FALSE_CARR] = false_carrier_i;
	assign lh_clear[`PSNP_LH_RX_ERR]     = rd_rx_err;
	assign lh_clear[`PSNP_LH_FALSE_CARR] = rd_fc;
	assign rx_err_latch = lh_flag[`PSNP_LH_RX_ERR];
	assign fc_latch     = lh_flag[`PSNP_LH_FALSE_CARR];
	assign rx_err_count = lh_count[`PSNP_LH_RX_ERR*`PSNP_CNT_W +: `PSNP_CNT_W];
	assign fc_count     = lh_count[`PSNP_LH_FALSE_CARR*`PSNP_CNT_W +: `PSNP_CNT_W];

	genvar gc;
	generate
		for (gc = 0; gc < `PSNP_LH_W; gc = gc + 1)
		begin : g_counter
			psnp_event_counter u_cnt (
				.clock_i (clock_i),
				.rst_b_i (rst_b_i),
				.event_i (lh_event[gc]),
				.clear_i (lh_clear[gc]),
				.count_o (lh_count[gc*`PSNP_CNT_W +: `PSNP_CNT_W]),
				.flag_o  (lh_flag[gc])
			);
		end
	endgenerate

	reg polarity_latch;

	always @(posedge clock_i)
	begin
		if (!rst_b_i)
			polarity_latch <= 1'b0;
		else if (rd_ten)
			polarity_latch <= polarity_inverted_i;
		else if (polarity_inverted_i)
			polarity_latch <= 1'b1;
	end

	// ------------------------------------------------------------------
	// latched-low status
	// ------------------------------------------------------------------
	wire qualified_live = qualify_detect ? (raw_signal_detect_i & descrambler_lock_i)
	                                     : raw_signal_detect_i;
	wire [`PSNP_LL_W-1:0] ll_live;
	wire [`PSNP_LL_W-1:0] ll_held;
	wire                  qualified_signal_detect;
	wire                  lock_held;

	// both bits reload together on any summary read
	assign ll_live[`PSNP_LL_DETECT] = qualified_live;
	assign ll_live[`PSNP_LL_LOCK]   = descrambler_lock_i;
	assign qualified_signal_detect  = ll_held[`PSNP_LL_DETECT];
	assign lock_held                = ll_held[`PSNP_LL_LOCK];

	genvar gl;
	generate
		for (gl = 0; gl < `PSNP_LL_W; gl = gl + 1)
		begin : g_latch_low
			psnp_latch_low u_ll (
				.clock_i (clock_i),
				.rst_b_i (rst_b_i),
				.live_i  (ll_live[gl]),
				.read_i  (rd_summary),
				.held_o  (ll_held[gl])
			);
		end
	endgenerate

	// ------------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------------
	reg  [`PSNP_EV_W-1:0] irq_status;
	reg  [`PSNP_EV_W-1:0] irq_mask;
	reg                   detect_prev;
	wire [`PSNP_EV_W-1:0] irq_event;

	// signal loss is the falling edge of the live detect, not of the held bit
	assign irq_event[`PSNP_EV_RX_ERR]     = rx_error_i;
	assign irq_event[`PSNP_EV_FALSE_CARR] = false_carrier_i;
	assign irq_event[`PSNP_EV_POLARITY]   = polarity_inverted_i & ~polarity_latch;
	assign irq_event[`PSNP_EV_SIG_LOSS]   = detect_prev & ~qualified_live;

	always @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			irq_status  <= {`PSNP_EV_W{1'b0}};
			irq_mask    <= {`PSNP_EV_W{1'b0}};
			detect_prev <= 1'b0;
			irq_o       <= 1'b0;
		end
		else
		begin
			detect_prev <= qualified_live;
			// set wins over a write-one clear in the same cycle
			if (wr_istat)
				irq_status <= (irq_status & ~wdata_i[`PSNP_EV_W-1:0]) | irq_event;
			else
				irq_status <= irq_status | irq_event;
			if (wr_imask)
				irq_mask <= wdata_i[`PSNP_EV_W-1:0];
			irq_o <= |(irq_status & irq_mask);
		end
	end

	// ------------------------------------------------------------------
	// read data
	// ------------------------------------------------------------------
	reg [`PSNP_DW-1:0] next_rdata;

	always @*
	begin
		next_rdata = {`PSNP_DW{1'b0}};
		case (addr_i)
			`PSNP_ADDR_NEXT_PAGE:
			begin
				next_rdata[`PSNP_NP_CODE_HI:0]     = np_code_o;
				next_rdata[`PSNP_NP_TOGGLE_BIT]    = toggle_tx_i;
				next_rdata[`PSNP_NP_ACK2_BIT]      = ack2_flag;
				next_rdata[`PSNP_NP_MSG_BIT]       = message_page_flag_o;
				next_rdata[`PSNP_NP_NEXT_BIT]      = next_page_flag;
			end
			`PSNP_ADDR_SUMMARY:
				next_rdata = {1'b0,
				              crossover_state_o,
				              rx_err_latch,
				              polarity_latch,
				              fc_latch,
				              qualified_signal_detect,
				              lock_held,
				              `PSNP_ST_LOW_ZERO};
			`PSNP_ADDR_IRQ_STATUS:
				next_rdata[`PSNP_EV_W-1:0] = irq_status;
			`PSNP_ADDR_IRQ_MASK:
				next_rdata[`PSNP_EV_W-1:0] = irq_mask;
			`PSNP_ADDR_FALSE_CARR:
				next_rdata[`PSNP_CNT_W-1:0] = fc_count;
			`PSNP_ADDR_RX_ERR:
				next_rdata[`PSNP_CNT_W-1:0] = rx_err_count;
			`PSNP_ADDR_PCS_CFG:
				next_rdata[`PSNP_CFG_QUALIFY_BIT] = qualify_detect;
			`PSNP_ADDR_PHY_CTRL:
			begin
				next_rdata[`PSNP_CTRL_AUTO_BIT]  = crossover_auto_enable;
				next_rdata[`PSNP_CTRL_FORCE_BIT] = crossover_force;
			end
			`PSNP_ADDR_TENBASE:
				next_rdata[`PSNP_TEN_POL_BIT] = polarity_latch;
			default:
				next_rdata = {`PSNP_DW{1'b0}};
		endcase
	end

	// data stand one cycle only, zero otherwise
	always @(posedge clock_i)
	begin
		if (!rst_b_i)
			rdata_o <= {`PSNP_DW{1'b0}};
		else if (rd_i)
			rdata_o <= next_rdata;
		else
			rdata_o <= {`PSNP_DW{1'b0}};
	end

endmodule // psnp_regs

// *** verification/psnp_regs_assertions.sv ***
/*
 * Checker for psnp_regs: read data of the summary status word, latches
 * and the next-page code field.
 * Sees only the top module's ports; bound to every psnp_regs below.
 */
`timescale 1ns/1ps
`include "psnp_defines.vh"

module psnp_regs_assertions (
	input wire                          clock_i,
	input wire                          rst_b_i,
	input wire [`PSNP_AW-1:0]           addr_i,
	input wire [`PSNP_DW-1:0]           wdata_i,
	input wire                          wr_i,
	input wire                          rd_i,
	input wire [`PSNP_DW-1:0]           rdata_o,
	input wire                          rx_error_i,
	input wire                          false_carrier_i,
	input wire                          raw_signal_detect_i,
	input wire                          descrambler_lock_i,
	input wire [`PSNP_NP_CODE_W-1:0]    np_code_o,
	input wire                          message_page_flag_o,
	input wire                          crossover_state_o
);
	// ------------------------------------------------------------
	// access decode
	// ------------------------------------------------------------
	wire                rd10 = rd_i && addr_i == `PSNP_ADDR_SUMMARY;
	wire                rd14 = rd_i && addr_i == `PSNP_ADDR_FALSE_CARR;
	wire                rd15 = rd_i && addr_i == `PSNP_ADDR_RX_ERR;
	wire                wr07 = wr_i && addr_i == `PSNP_ADDR_NEXT_PAGE;
	reg  [`PSNP_DW-1:0] wd_q;

	always @(posedge clock_i)
		wd_q <= wdata_i;

	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	a_bit15_zero: assert property (rd10 |=> !rdata_o[15])
		else $error("status bit 15 read as one");
	a_xover_shown: assert property (rd10 |=> rdata_o[14] == $past(crossover_state_o))
		else $error("status bit 14 differs from crossover state");
	a_rxerr_seen: assert property (rx_error_i ##1 rd10 |=> rdata_o[13])
		else $error("receive error not latched");
	a_rxerr_clear: assert property ((rd15 && !rx_error_i) ##1 !rx_error_i ##1 rd10 |=> !rdata_o[13])
		else $error("receive error latch not cleared by counter read");
	a_fc_seen: assert property (false_carrier_i ##1 rd10 |=> rdata_o[11])
		else $error("false carrier not latched");
	a_fc_clear: assert property ((rd14 && !false_carrier_i) ##1 !false_carrier_i ##1 rd10 |=> !rdata_o[11])
		else $error("false carrier latch not cleared by counter read");
	a_detect_low: assert property (!raw_signal_detect_i ##1 !rd10 ##1 rd10 |=> !rdata_o[10])
		else $error("loss of signal detect not held");
	a_lock_low: assert property (!descrambler_lock_i ##1 !rd10 ##1 rd10 |=> !rdata_o[9])
		else $error("loss of descrambler lock not held");
	a_np_write: assert property (wr07 |=> np_code_o == wd_q[10:0] && message_page_flag_o == wd_q[13])
		else $error("next-page write not taken");
	a_np_hold: assert property (!wr07 |=> $stable(np_code_o) && $stable(message_page_flag_o))
		else $error("next-page field changed without a write");
endmodule // psnp_regs_assertions

bind psnp_regs psnp_regs_assertions u_chk (
	.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_error_i(rx_error_i),
	.false_carrier_i(false_carrier_i), .raw_signal_detect_i(raw_signal_detect_i),
	.descrambler_lock_i(descrambler_lock_i), .np_code_o(np_code_o),
	.message_page_flag_o(message_page_flag_o), .crossover_state_o(crossover_state_o)
);

// *** verification/psnp_regs_tb_top.sv ***
/*
 * Bench for psnp_regs: drives the register port and live status inputs,
 * checks read data through a queue of expected words.
 * Assumes the design files and psnp_defines.vh on the include path.
 */
`timescale 1ns/1ps
`include "psnp_defines.vh"

module psnp_regs_tb_top;
	logic                       clock_i = 1'b0;
	logic                       rst_b_i = 1'b0;
	logic [`PSNP_AW-1:0]        addr_i = 5'h00;
	logic [`PSNP_DW-1:0]        wdata_i = 16'h0000;
	logic                       wr_i = 1'b0;
	logic                       rd_i = 1'b0;
	logic [`PSNP_DW-1:0]        rdata_o;
	logic                       xover_swap_i = 1'b0;
	logic                       rx_error_i = 1'b0;
	logic                       false_carrier_i = 1'b0;
	logic                       polarity_inverted_i = 1'b0;
	logic                       raw_signal_detect_i = 1'b1;
	logic                       descrambler_lock_i = 1'b1;
	logic                       toggle_tx_i = 1'b0;
	logic [`PSNP_NP_CODE_W-1:0] np_code_o;
	logic                       message_page_flag_o;
	logic                       crossover_state_o;
	logic                       irq_o;
	logic [15:0]                exq[$];
	logic [15:0]                mkq[$];
	logic                       rd_seen = 1'b0;
	logic [15:0]                d;
	logic [15:0]                xc[4] = '{16'h8000, 16'h0000, 16'h4000, 16'h8000};
	logic [3:0]                 xs = 4'b0011;
	logic [3:0]                 xe = 4'b0101;
	logic [5:0]                 dx = 6'b011000;
	int                         miscompares = 0;
	int                         n_compared = 0;
	int                         k;

	always #50 clock_i = ~clock_i;

	psnp_regs i_dut (
		.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .xover_swap_i(xover_swap_i),
		.rx_error_i(rx_error_i), .false_carrier_i(false_carrier_i),
		.polarity_inverted_i(polarity_inverted_i), .raw_signal_detect_i(raw_signal_detect_i),
		.descrambler_lock_i(descrambler_lock_i), .toggle_tx_i(toggle_tx_i),
		.np_code_o(np_code_o), .message_page_flag_o(message_page_flag_o),
		.crossover_state_o(crossover_state_o), .irq_o(irq_o)
	);

	// ------------------------------------------------------------
	// compare, bus tasks, verdict
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] e, input logic [15:0] m);
		n_compared++;
		if ((got & m) !== (e & m))
		begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, got, e);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		wt(1);
		wr_i <= 1'b0;
		wt(1);
	endtask

	// one idle cycle after each strobe keeps a strobe from being set twice in a step
	task automatic rd(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
		exq.push_back(e);
		mkq.push_back(m);
		addr_i <= a;
		rd_i <= 1'b1;
		wt(1);
		rd_i <= 1'b0;
		wt(1);
	endtask

	task automatic irq_is(input logic e);
		@(negedge clock_i);
		chk({15'h0000, irq_o}, {15'h0000, e}, 16'h0001);
		wt(1);
	endtask

	function automatic logic [15:0] st(input logic [5:0] b);
		st = {1'b0, b, 9'h000};
	endfunction

	task automatic wrap_up;
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clock_i)
		rd_seen <= rd_i;
	always @(negedge clock_i)
		if (rd_seen)
			chk(rdata_o, exq.pop_front(), mkq.pop_front());

	initial
	begin
		wt(3000);
		miscompares++;
		wrap_up;
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin
		d = $urandom(79);
		wt(4);
		rst_b_i <= 1'b1;
		irq_is(1'b0);
		rd(`PSNP_ADDR_NEXT_PAGE, 16'h2001, 16'hFFFF);
		rd(5'h1F, 16'h0000, 16'hFFFF);
		rd(`PSNP_ADDR_IRQ_MASK, 16'h0000, 16'hFFFF);
		wr(`PSNP_ADDR_SUMMARY, 16'hFFFF);
		rd(`PSNP_ADDR_SUMMARY, st(6'b000000), 16'hFFFF);
		rd(`PSNP_ADDR_SUMMARY, st(6'b000011), 16'hFFFF);
		for (k = 0; k < 3; k++)
		begin
			d = $urandom;
			toggle_tx_i <= d[14];
			wr(`PSNP_ADDR_NEXT_PAGE, d);
			chk({4'h0, message_page_flag_o, np_code_o}, {4'h0, d[13], d[10:0]}, 16'hFFFF);
			rd(`PSNP_ADDR_NEXT_PAGE, (d & 16'hB7FF) | {4'h0, d[14], 11'h000}, 16'hFFFF);
		end
		// mid-run reset: register values and latches must go back to their reset state
		rst_b_i <= 1'b0;
		toggle_tx_i <= 1'b0;
		wt(2);
		rst_b_i <= 1'b1;
		rd(`PSNP_ADDR_NEXT_PAGE, 16'h2001, 16'hFFFF);
		rd(`PSNP_ADDR_SUMMARY, st(6'b000000), 16'hFFFF);
		for (k = 0; k < 4; k++)
		begin
			xover_swap_i <= xs[k];
			wr(`PSNP_ADDR_PHY_CTRL, xc[k]);
			wt(1);
			chk({15'h0000, crossover_state_o}, {15'h0000, xe[k]}, 16'h0001);
			rd(`PSNP_ADDR_SUMMARY, st({xe[k], 5'b00011}), 16'hFFFF);
		end
		for (k = 0; k < 2; k++)
		begin
			rx_error_i <= (k == 0);
			false_carrier_i <= (k == 1);
			wt(3);
			rx_error_i <= 1'b0;
			false_carrier_i <= 1'b0;
			rd(`PSNP_ADDR_SUMMARY, st(k ? 6'b000111 : 6'b010011), 16'hFFFF);
			rd(`PSNP_ADDR_SUMMARY, st(k ? 6'b000111 : 6'b010011), 16'hFFFF);
			rd(k ? `PSNP_ADDR_FALSE_CARR : `PSNP_ADDR_RX_ERR, 16'h0003, 16'h00FF);
			rd(`PSNP_ADDR_SUMMARY, st(6'b000011), 16'hFFFF);
		end
		irq_is(1'b0);
		for (k = 0; k < 2; k++)
		begin
			wr(`PSNP_ADDR_IRQ_MASK, 16'h0001 << k);
			irq_is(1'b1);
			rd(`PSNP_ADDR_IRQ_STATUS, 16'h0003 << k, 16'h0003);
			wr(`PSNP_ADDR_IRQ_STATUS, 16'h0001 << k);
			irq_is(1'b0);
		end
		polarity_inverted_i <= 1'b1;
		wt(2);
		polarity_inverted_i <= 1'b0;
		rd(`PSNP_ADDR_SUMMARY, st(6'b001011), 16'hFFFF);
		rd(`PSNP_ADDR_SUMMARY, st(6'b001011), 16'hFFFF);
		rd(`PSNP_ADDR_TENBASE, 16'h0010, 16'h0010);
		rd(`PSNP_ADDR_SUMMARY, st(6'b000011), 16'hFFFF);
		for (k = 0; k < 3; k++)
		begin
			wr(`PSNP_ADDR_PCS_CFG, {7'h00, k == 0, 8'h00});
			raw_signal_detect_i <= (k != 2);
			descrambler_lock_i <= (k == 2);
			wt(1);
			raw_signal_detect_i <= 1'b1;
			descrambler_lock_i <= 1'b1;
			wt(1);
			rd(`PSNP_ADDR_SUMMARY, st({4'h0, dx[2*k +: 2]}), 16'hFFFF);
			rd(`PSNP_ADDR_SUMMARY, st(6'b000011), 16'hFFFF);
		end
		wrap_up;
	end
endmodule // psnp_regs_tb_top
